// file: tb/sec_link_checker.sv
// concurrent checks on the link between the host and eeprom ends
`timescale 1ns/100ps
module sec_link_checker import sec_pkg::*; #(
    parameter logic [TIMER_W-1:0] WRITE_TICKS = 21'hc8
) (
    // system
    input wire logic clk,
    input wire logic rstn,
    input wire logic vdd_ok,
    // link
    input wire logic cs,
    input wire logic sk,
    input wire logic di,
    input wire logic do_out,
    input wire logic do_oe,
    // device status
    input wire logic busy,
    input wire logic write_enabled
);
    logic [TIMER_W-1:0] bcnt_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // cycles of the running internal write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            bcnt_reg <= '0;
        else
            bcnt_reg <= busy ? bcnt_reg + 1'b1 : '0;
    end

    sk_parked_a: assert property (!cs |-> !sk)
        else $error("sk moved while deselected");
    idle_release_a: assert property ($fell(cs) |-> ##[1:3] !do_oe)
        else $error("do still driven after deselect");
    oe_needs_sel_a: assert property ($rose(do_oe) |-> $past(cs, 2))
        else $error("do driven without select");
    write_gate_a:
        assert property ($rose(busy) |-> !cs && $past(write_enabled))
        else $error("write started while selected or disabled");
    write_len_a:
        assert property ($fell(busy) |-> bcnt_reg == WRITE_TICKS)
        else $error("internal write length wrong");
    busy_low_a: assert property (cs && do_oe && busy |-> !do_out)
        else $error("do not low while busy");
    poll_di_low_a: assert property (do_oe && busy |-> !di)
        else $error("di high during polling");
    latch_desel_a:
        assert property ($rose(write_enabled) |-> !cs && vdd_ok)
        else $error("latch set while selected or supply low");
    vdd_lock_a: assert property (!vdd_ok [*4] |-> !write_enabled)
        else $error("latch kept with supply low");

    cover property (cs && do_oe && busy);
    cover property ($rose(write_enabled));
    cover property ($fell(busy) ##[1:400] (cs && do_oe && do_out));
endmodule // sec_link_checker

// file: tb/testbench.sv
// self-checking bench joining host and eeprom ends over the link
`timescale 1ns/100ps
module testbench import sec_pkg::*; ;
    localparam logic [TIMER_W-1:0] TICKS = 21'hc8;
    logic            clk, rstn, vdd_ok, busy, write_enabled;
    logic            cmd_valid, cmd_ready, rd_valid, done, poll_fail;
    sec_cmd_t        cmd_op;
    logic [AW-1:0]   cmd_addr, cmd_extra;
    logic [DW-1:0]   cmd_data, rd_data;
    int              n_mismatch, cmp_count, cyc, a;
    int              mem [WORDS];
    bit              we;

    sec_link_if sec_link_if_inst ();
    sec_eeprom_dev #(.WRITE_TICKS(TICKS)) sec_eeprom_dev_inst (
        .clk(clk), .rstn(rstn), .vdd_ok(vdd_ok), .link(sec_link_if_inst),
        .busy(busy), .write_enabled(write_enabled));
    sec_eeprom_host #(.POLL_TICKS(21'h7d0)) sec_eeprom_host_inst (
        .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_extra(cmd_extra), .rd_valid(rd_valid), .rd_data(rd_data),
        .done(done), .poll_fail(poll_fail), .link(sec_link_if_inst));
    sec_link_checker #(.WRITE_TICKS(TICKS)) sec_link_checker_inst (
        .clk(clk), .rstn(rstn), .vdd_ok(vdd_ok), .cs(sec_link_if_inst.cs),
        .sk(sec_link_if_inst.sk), .di(sec_link_if_inst.di),
        .do_out(sec_link_if_inst.do_out), .do_oe(sec_link_if_inst.do_oe),
        .busy(busy), .write_enabled(write_enabled));

    task automatic chk(string nm, logic [DW-1:0] exp_v, logic [DW-1:0] got);
        cmp_count++;
        if (got !== exp_v) begin
            $display("unexpected %s: expected %h seen %h", nm, exp_v, got);
            n_mismatch++;
        end
    endtask

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one command through the host port; model updated after done
    task automatic run(sec_cmd_t op, int ad, int d, int x);
        int k;
        bit wr_ok;
        k = 0;
        // surplus clocks on a write frame must cancel it
        wr_ok = we && x == 0;
        cmd_op = op;
        cmd_addr = 8'(ad);
        cmd_data = 16'(d);
        cmd_extra = 8'(x);
        cmd_valid = 1'b1;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        while (done !== 1'b1) begin
            @(posedge clk);
            #1;
            if (rd_valid === 1'b1) begin
                chk("rd_data", 16'(mem[(ad + k) % WORDS]), rd_data);
                k++;
            end
        end
        chk("cmd_ready", 16'h1, {15'h0, cmd_ready});
        chk("busy", 16'h0, {15'h0, busy});
        if (op inside {CMD_WRITE, CMD_ERASE, CMD_ARRAY_W, CMD_ARRAY_E})
            chk("poll_fail", {15'h0, !wr_ok}, {15'h0, poll_fail});
        case (op)
            CMD_READ: chk("words", 16'(x + 1), 16'(k));
            CMD_WRITE: if (wr_ok) mem[ad] = d;
            CMD_ERASE: if (wr_ok) mem[ad] = 32'hffff;
            CMD_ARRAY_W: if (wr_ok) foreach (mem[i]) mem[i] = d;
            CMD_ARRAY_E: if (wr_ok) foreach (mem[i]) mem[i] = 32'hffff;
            CMD_W_ENABLE: we = 1'b1;
            default: we = 1'b0;
        endcase
        chk("write_enabled", {15'h0, we}, {15'h0, write_enabled});
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        rstn = 1'b0;
        vdd_ok = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = CMD_READ;
        cmd_addr = '0;
        cmd_data = '0;
        cmd_extra = '0;
        foreach (mem[i]) mem[i] = 32'hffff;
        void'($urandom(42));
        repeat (20) @(posedge clk);
        #1 rstn = 1'b1;
        run(CMD_READ, 254, 0, 2);
        a = $urandom % WORDS;
        run(CMD_WRITE, a, 32'h1234, 0);
        run(CMD_READ, a, 0, 0);
        run(CMD_W_ENABLE, 0, 0, 0);
        run(CMD_WRITE, a, 32'h0f0f, 2);
        run(CMD_READ, a, 0, 0);
        repeat (3) begin
            a = $urandom % WORDS;
            run(CMD_WRITE, a, $urandom & 32'hffff, 0);
            run(CMD_WRITE, a, $urandom & 32'hffff, 0);
            run(CMD_READ, a, 0, 1);
            run(CMD_ERASE, a, 0, 0);
            run(CMD_READ, a, 0, 0);
        end
        run(CMD_ARRAY_W, $urandom % WORDS, $urandom & 32'hffff, 0);
        run(CMD_READ, $urandom % WORDS, 0, 3);
        run(CMD_ARRAY_E, 0, 0, 0);
        run(CMD_READ, 255, 0, 1);
        run(CMD_ARRAY_W, 0, 32'h5a5a, 0);
        run(CMD_W_DISABL, 0, 0, 0);
        run(CMD_ARRAY_E, 0, 0, 0);
        run(CMD_READ, 10, 0, 0);
        run(CMD_W_ENABLE, 0, 0, 0);
        // supply dip must drop the latch
        vdd_ok = 1'b0;
        we = 1'b0;
        repeat (8) @(posedge clk);
        #1 vdd_ok = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("write_enabled", 16'h0, {15'h0, write_enabled});
        run(CMD_ERASE, 3, 0, 0);
        run(CMD_READ, 3, 0, 0);
        give_verdict();
    end
endmodule // testbench

// file: verilog/sec_eeprom_dev.sv
// serial eeprom end: command engine, write timer and word array
`timescale 1ns/100ps
module sec_eeprom_dev import sec_pkg::*; #(
    parameter logic [TIMER_W-1:0] WRITE_TICKS = TIMER_W'(WRITE_CYCLES)
) (
    // system
    input  wire logic   clk,
    input  wire logic   rstn,
    // supply detector, high when supply is good
    input  wire logic   vdd_ok,
    // link
    sec_link_if.dev     link,
    // status
    output logic        busy,
    output logic        write_enabled
);

    typedef enum logic [2:0] {
        P_WAIT  = 3'b001,
        P_SHIFT = 3'b010,
        P_READ  = 3'b100
    } sec_phase_t;

    typedef struct packed {
        sec_phase_t    phase;
        logic [5:0]    cnt;
        logic [1:0]    op;
        logic [1:0]    ext;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
        logic [3:0]    idx;
        logic [DW-1:0] word;
        logic          tog;
        logic          do_en;
        logic          do_val;
    } sec_sk_t;

    typedef struct packed {
        logic               cs_s1;
        logic               cs_s2;
        logic               cs_d;
        logic               vdd_s1;
        logic               vdd_s2;
        logic               tog_s1;
        logic               tog_s2;
        logic               tog_d;
        logic               en_s1;
        logic               en_s2;
        logic               val_s1;
        logic               val_s2;
        logic               wen;
        logic               busy;
        logic               verify;
        logic               blocked;
        logic               fresh;
        logic [TIMER_W-1:0] timer;
        logic               do_out;
        logic               do_oe;
    } sec_core_t;

    localparam sec_sk_t SK_RESET = '{phase: P_WAIT, default: '0};

    sec_sk_t       s_reg;
    sec_sk_t       s_next;
    sec_core_t     c_reg;
    sec_core_t     c_next;
    logic          frame_reg;
    logic          frame_rstn;
    logic [DW-1:0] mem [WORDS] = '{default: ERASED_WORD};
    logic          exec;
    logic          ctl_go;
    logic          wr_go;
    logic          wr_all;
    logic [DW-1:0] wr_val;

    // ---------------- link clock domain ----------------
    // deselect clears frame
    assign frame_rstn = rstn & link.cs;

    always_ff @(posedge link.sk or negedge frame_rstn) begin
        if (!frame_rstn) begin
            frame_reg <= 1'b0;
        end else begin
            frame_reg <= 1'b1;
        end
    end

    always_comb begin
        s_next = s_reg;
        // first edge of a frame forgets the last one
        if (!frame_reg) begin
            s_next.phase = P_WAIT;
            s_next.do_en = 1'b0;
        end
        case (s_next.phase)
            P_WAIT: begin
                if (link.di) begin
                    s_next.phase = P_SHIFT;
                    s_next.cnt   = 6'h0;
                    s_next.op    = 2'h0;
                    s_next.ext   = 2'h0;
                    s_next.addr  = '0;
                    s_next.data  = '0;
                    s_next.tog   = ~s_reg.tog;
                    s_next.do_en = 1'b0;
                end
            end
            P_SHIFT: begin
                if (s_reg.cnt != CNT_SAT) begin
                    s_next.cnt = s_reg.cnt + 6'h1;
                end
                if (s_reg.cnt < 6'h2) begin
                    s_next.op = {s_reg.op[0], link.di};
                end else if (s_reg.cnt < CNT_ADDR_END) begin
                    s_next.addr = {s_reg.addr[AW-2:0], link.di};
                    if (s_reg.cnt < CNT_EXT_MIN) begin
                        s_next.ext = {s_reg.ext[0], link.di};
                    end
                end else if (s_reg.cnt < CNT_DATA_END) begin
                    s_next.data = {s_reg.data[DW-2:0], link.di};
                end
                if (s_reg.op == OP_READ
                        && s_reg.cnt == CNT_ADDR_END - 6'h1) begin
                    s_next.phase  = P_READ;
                    s_next.word   = mem[s_next.addr];
                    s_next.idx    = 4'h0;
                    s_next.do_en  = 1'b1;
                    s_next.do_val = 1'b0;
                end
            end
            P_READ: begin
                s_next.do_val = s_reg.word[DW-1];
                s_next.word   = {s_reg.word[DW-2:0], 1'b0};
                s_next.idx    = s_reg.idx + 4'h1;
                if (s_reg.idx == 4'hf) begin
                    s_next.addr = AW'(s_reg.addr + 1'b1);
                    s_next.word = mem[s_next.addr];
                end
            end
            default: begin
                s_next.phase = P_WAIT;
            end
        endcase
    end

    always_ff @(posedge link.sk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= SK_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------- system clock domain ----------------
    // frame fields are read only after deselect, when sk is quiet
    always_comb begin
        c_next        = c_reg;
        c_next.cs_s1  = link.cs;
        c_next.cs_s2  = c_reg.cs_s1;
        c_next.cs_d   = c_reg.cs_s2;
        c_next.vdd_s1 = vdd_ok;
        c_next.vdd_s2 = c_reg.vdd_s1;
        c_next.tog_s1 = s_reg.tog;
        c_next.tog_s2 = c_reg.tog_s1;
        c_next.tog_d  = c_reg.tog_s2;
        c_next.en_s1  = s_reg.do_en;
        c_next.en_s2  = c_reg.en_s1;
        c_next.val_s1 = s_reg.do_val;
        c_next.val_s2 = c_reg.val_s1;

        if (c_reg.cs_s2 && !c_reg.cs_d) begin
            c_next.fresh   = 1'b0;
            c_next.blocked = c_reg.busy;
        end
        if ((c_reg.tog_s2 ^ c_reg.tog_d) && !c_reg.busy) begin
            c_next.fresh  = 1'b1;
            c_next.verify = 1'b0;
        end

        // only on deselect, never while busy
        exec = c_reg.cs_d && !c_reg.cs_s2 && c_reg.fresh
            && !c_reg.blocked && s_reg.phase == P_SHIFT;
        ctl_go = exec && s_reg.op == OP_EXT && s_reg.cnt >= CNT_EXT_MIN
            && (s_reg.ext == EXT_ENABLE || s_reg.ext == EXT_DISABLE);
        wr_go = exec && c_reg.wen && c_reg.vdd_s2 && s_reg.op != OP_READ
            && !(s_reg.op == OP_EXT
                 && (s_reg.ext == EXT_ENABLE || s_reg.ext == EXT_DISABLE))
            && s_reg.cnt == sec_frame_bits(s_reg.op, s_reg.ext);
        wr_all = s_reg.op == OP_EXT;
        wr_val = (s_reg.op == OP_ERASE
                  || (s_reg.op == OP_EXT && s_reg.ext == EXT_ARRAY_E))
            ? ERASED_WORD : s_reg.data;

        if (ctl_go) begin
            c_next.wen = (s_reg.ext == EXT_ENABLE);
        end
        // fixed write time below the maximum
        if (c_reg.busy) begin
            if (c_reg.timer == '0) begin
                c_next.busy = 1'b0;
            end else begin
                c_next.timer = c_reg.timer - 1'b1;
            end
        end
        if (wr_go) begin
            c_next.busy   = 1'b1;
            c_next.verify = 1'b1;
            c_next.timer  = WRITE_TICKS - 1'b1;
        end
        if (!c_reg.vdd_s2) begin
            c_next.wen = 1'b0;
        end

        if (!c_reg.cs_s2) begin
            c_next.do_oe  = 1'b0;
            c_next.do_out = 1'b0;
        end else if (c_reg.verify && !c_next.fresh) begin
            c_next.do_oe  = 1'b1;
            c_next.do_out = ~c_next.busy;
        end else if (c_next.fresh) begin
            c_next.do_oe  = c_reg.en_s2;
            c_next.do_out = c_reg.val_s2;
        end else begin
            c_next.do_oe  = 1'b0;
            c_next.do_out = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            c_reg <= '0;
        end else begin
            c_reg <= c_next;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_go) begin
            if (wr_all) begin
                for (int i = 0; i < WORDS; i++) begin
                    mem[i] <= wr_val;
                end
            end else begin
                mem[s_reg.addr] <= wr_val;
            end
        end
    end

    assign link.do_out   = c_reg.do_out;
    assign link.do_oe    = c_reg.do_oe;
    assign busy          = c_reg.busy;
    assign write_enabled = c_reg.wen;

endmodule // sec_eeprom_dev

// file: verilog/sec_eeprom_host.sv
// host end: frames commands onto the link and polls write completion
`timescale 1ns/100ps
module sec_eeprom_host import sec_pkg::*; #(
    parameter logic [TIMER_W-1:0] POLL_TICKS = TIMER_W'(MAX_WRITE_CYCLES)
) (
    // system
    input  wire logic   clk,
    input  wire logic   rstn,
    // command
    input  wire logic   cmd_valid,
    output logic        cmd_ready,
    input  wire sec_cmd_t cmd_op,
    input  wire logic [AW-1:0] cmd_addr,
    input  wire logic [DW-1:0] cmd_data,
    input  wire logic [AW-1:0] cmd_extra,
    // answers
    output logic        rd_valid,
    output logic [DW-1:0] rd_data,
    output logic        done,
    output logic        poll_fail,
    // link
    sec_link_if.host    link
);

    typedef enum logic [5:0] {
        H_IDLE  = 6'b000001,
        H_SETUP = 6'b000010,
        H_LOW   = 6'b000100,
        H_HIGH  = 6'b001000,
        H_DESEL = 6'b010000,
        H_POLL  = 6'b100000
    } sec_hstate_t;

    typedef struct packed {
        sec_hstate_t        st;
        logic [TIMER_W-1:0] tmr;
        logic [12:0]        rises;
        logic [12:0]        total;
        logic [5:0]         ntx;
        logic [TXW-1:0]     tx;
        logic [DW-1:0]      rx;
        logic [3:0]         rxn;
        logic               wr_kind;
        logic               do_s1;
        logic               do_s2;
        logic               cs;
        logic               sk;
        logic               di;
        logic               ready;
        logic               rd_valid;
        logic [DW-1:0]      rd_data;
        logic               done;
        logic               fail;
    } sec_host_t;

    localparam sec_host_t H_RESET = '{st: H_IDLE, ready: 1'b1, default: '0};
    localparam logic [TIMER_W-1:0] HALF  = TIMER_W'(SK_HALF_CYCLES - 1);
    localparam logic [TIMER_W-1:0] DESEL = TIMER_W'(DESEL_CYCLES - 1);

    sec_host_t     h_reg;
    sec_host_t     h_next;
    logic [1:0]    op;
    logic [1:0]    ext;
    logic [AW-1:0] afield;

    always_comb begin
        h_next          = h_reg;
        h_next.do_s1    = link.do_line;
        h_next.do_s2    = h_reg.do_s1;
        h_next.rd_valid = 1'b0;
        h_next.done     = 1'b0;
        op  = OP_EXT;
        ext = EXT_DISABLE;
        case (cmd_op)
            CMD_READ:     op  = OP_READ;
            CMD_WRITE:    op  = OP_WRITE;
            CMD_ERASE:    op  = OP_ERASE;
            CMD_ARRAY_W:  ext = EXT_ARRAY_W;
            CMD_ARRAY_E:  ext = EXT_ARRAY_E;
            CMD_W_ENABLE: ext = EXT_ENABLE;
            default:      ext = EXT_DISABLE;
        endcase
        afield = (op == OP_EXT) ? {ext, {(AW-2){1'b0}}} : cmd_addr;

        case (h_reg.st)
            H_IDLE: begin
                if (cmd_valid && h_reg.ready) begin
                    h_next.tx      = {1'b1, op, afield, cmd_data};
                    h_next.ntx     = 6'h1 + sec_frame_bits(op, ext);
                    h_next.total   = 13'h1 + 13'(sec_frame_bits(op, ext));
                    if (op == OP_READ) begin
                        h_next.total = h_next.total
                            + 13'((32'(cmd_extra) + 32'd1) * DW);
                    end else begin
                        // surplus clocks let a user probe the count monitor
                        h_next.total = h_next.total + 13'(cmd_extra);
                    end
                    h_next.wr_kind = !(op == OP_READ || (op == OP_EXT
                        && (ext == EXT_ENABLE || ext == EXT_DISABLE)));
                    h_next.rises   = 13'h0;
                    h_next.rxn     = 4'h0;
                    h_next.ready   = 1'b0;
                    h_next.cs      = 1'b1;
                    h_next.tmr     = HALF;
                    h_next.st      = H_SETUP;
                end
            end
            H_SETUP, H_HIGH: begin
                if (h_reg.tmr == '0) begin
                    h_next.di  = h_reg.tx[TXW-1];
                    h_next.tx  = {h_reg.tx[TXW-2:0], 1'b0};
                    h_next.sk  = 1'b0;
                    h_next.tmr = HALF;
                    h_next.st  = H_LOW;
                    if (h_reg.st == H_HIGH) begin
                        h_next.rises = h_reg.rises + 13'h1;
                    end
                end else begin
                    h_next.tmr = h_reg.tmr - 1'b1;
                end
            end
            H_LOW: begin
                if (h_reg.tmr == '0) begin
                    // last address rise shows the dummy bit, so sampling starts one rise later
                    if (h_reg.rises > 13'(h_reg.ntx)) begin
                        h_next.rx  = {h_reg.rx[DW-2:0], h_reg.do_s2};
                        h_next.rxn = h_reg.rxn + 4'h1;
                        if (h_reg.rxn == 4'hf) begin
                            h_next.rd_valid = 1'b1;
                            h_next.rd_data  = h_next.rx;
                        end
                    end
                    h_next.tmr = DESEL;
                    if (h_reg.rises == h_reg.total) begin
                        h_next.cs = 1'b0;
                        h_next.di = 1'b0;
                        h_next.st = H_DESEL;
                    end else begin
                        h_next.sk  = 1'b1;
                        h_next.tmr = HALF;
                        h_next.st  = H_HIGH;
                    end
                end else begin
                    h_next.tmr = h_reg.tmr - 1'b1;
                end
            end
            H_DESEL: begin
                if (h_reg.tmr != '0) begin
                    h_next.tmr = h_reg.tmr - 1'b1;
                end else if (h_reg.wr_kind) begin
                    h_next.cs  = 1'b1;
                    h_next.di  = 1'b0;
                    h_next.tmr = POLL_TICKS;
                    h_next.st  = H_POLL;
                end else begin
                    h_next.done  = 1'b1;
                    h_next.ready = 1'b1;
                    h_next.st    = H_IDLE;
                end
            end
            H_POLL: begin
                // a cancelled write never drives do, so give up in time
                if (h_reg.do_s2 == 1'b1 || h_reg.tmr == '0) begin
                    h_next.fail    = h_reg.do_s2 != 1'b1;
                    h_next.cs      = 1'b0;
                    h_next.wr_kind = 1'b0;
                    h_next.tmr     = DESEL;
                    h_next.st      = H_DESEL;
                end else begin
                    h_next.tmr = h_reg.tmr - 1'b1;
                end
            end
            default: begin
                h_next = H_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            h_reg <= H_RESET;
        end else begin
            h_reg <= h_next;
        end
    end

    assign link.cs   = h_reg.cs;
    assign link.sk   = h_reg.sk;
    assign link.di   = h_reg.di;
    assign cmd_ready = h_reg.ready;
    assign rd_valid  = h_reg.rd_valid;
    assign rd_data   = h_reg.rd_data;
    assign done      = h_reg.done;
    assign poll_fail = h_reg.fail;

endmodule // sec_eeprom_host

// file: verilog/sec_link_if.sv
// link wires between the host end and the eeprom end
`timescale 1ns/100ps
interface sec_link_if;
    logic cs;
    logic sk;
    logic di;
    logic do_out;
    logic do_oe;
    logic do_line;

    // released do reads low through the board pull-down, so a
    // cancelled write never looks ready to a polling host
    assign do_line = do_oe ? do_out : 1'b0;

    modport dev  (input cs, input sk, input di, output do_out, output do_oe);
    modport host (output cs, output sk, output di, input do_line);
endinterface

// file: verilog/sec_pkg.sv
// shared constants, types and helpers of the serial eeprom command link
package sec_pkg;
    localparam int unsigned WORDS = 256;
    localparam int unsigned AW    = $clog2(WORDS);
    localparam int unsigned DW    = 16;
    localparam int unsigned TXW   = 1 + 2 + AW + DW;

    localparam logic [DW-1:0] ERASED_WORD = 16'hffff;

    // two opcode bits after the start bit
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    // top two address bits of an OP_EXT frame
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_ARRAY_W = 2'h1;
    localparam logic [1:0] EXT_ARRAY_E = 2'h2;
    localparam logic [1:0] EXT_ENABLE  = 2'h3;

    // bit counts after the start bit
    localparam logic [5:0] CNT_EXT_MIN  = 6'h4;
    localparam logic [5:0] CNT_ADDR_END = 6'(2 + AW);
    localparam logic [5:0] CNT_DATA_END = 6'(2 + AW + DW);
    localparam logic [5:0] CNT_SAT      = 6'h3f;

    // timing
    localparam int unsigned CLK_MHZ                = 200;
    localparam int unsigned INTERNAL_WRITE_TIME_US = 4000;
    localparam int unsigned MAX_WRITE_TIME_US      = 8000;
    localparam int unsigned WRITE_CYCLES = INTERNAL_WRITE_TIME_US * CLK_MHZ;
    localparam int unsigned MAX_WRITE_CYCLES = MAX_WRITE_TIME_US * CLK_MHZ;
    localparam int unsigned DESELECT_MIN_TIME_NS = 200;
    localparam int unsigned DESEL_CYCLES =
        (DESELECT_MIN_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SK_HALF_CYCLES = 8;
    localparam int unsigned TIMER_W        = 21;

    typedef enum logic [2:0] {
        CMD_READ     = 3'h0,
        CMD_WRITE    = 3'h1,
        CMD_ERASE    = 3'h2,
        CMD_ARRAY_W  = 3'h3,
        CMD_ARRAY_E  = 3'h4,
        CMD_W_ENABLE = 3'h5,
        CMD_W_DISABL = 3'h6
    } sec_cmd_t;

    // exact bits after the start bit for a frame
    function automatic logic [5:0] sec_frame_bits(input logic [1:0] op,
                                                  input logic [1:0] ext);
        if (op == OP_WRITE || (op == OP_EXT && ext == EXT_ARRAY_W))
            return CNT_DATA_END;
        return CNT_ADDR_END;
    endfunction
endpackage
